/* File: rtl/bcr_boost_regs.sv */
// Purpose: register bank of a boost converter behind a serial target port
// Assumes: core_clk 25 MHz, rst_b is the power-on reset
// Notes:   analog flags and strap are synchronised before use
//
// Functional notes
// - target address is 11101 plus two strap bits, then direction bit
// - strap sampled once after power-on reset, address then held fixed
// - read-clear bits drop to zero when the host reads them
// - identity register is read-only: maker code high, version low
// - writing config bit 7 reloads all defaults; bit reads back zero
// - config bit 6 enables the converter, default on
// - bypass field: 00 low power, 01 forced, 1x automatic; default 10
// - config bit 3 discharges output while disabled, default on
// - output bit 7 disables power limit; config bit 2 picks 7A or 5A
// - config bit 1 enables spread spectrum in PWM
// - config bit 0: 0 light-load PFM, 1 forced PWM
// - output bit 6 raises amplifier on bypass-to-boost transition
// - output voltage code is also the boost/bypass threshold
// - reset values 0x68, 0x0B, 0x16 and status 0x10
// - reads above 0x04 return 0xFF
// - multi-byte writes and reads advance to the next address
// - thermal flag sets on trip and clears on host read
`timescale 1ns/1ns
module bcr_boost_regs #(
   parameter logic [3:0] MAKER_CODE   = 4'h5, // arbitrary value
   parameter logic [3:0] VERSION_CODE = 4'h3  // arbitrary value
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic [1:0]  addr_strap,
   // thermal, bypass limit, boost limit, fault
   input  wire logic [3:0]  event_in,
   // pfm active, dcdc active, power good
   input  wire logic [2:0]  live_in,
   output logic             converter_enable,
   output logic [1:0]       bypass_policy,
   output logic             output_discharge_enable,
   output logic             discharge_on,
   output logic             power_limit_level,
   output logic             power_limit_disable,
   output logic             spread_spectrum_enable,
   output logic             forced_pwm,
   output logic             loop_adjust_on_transition,
   output logic [5:0]       output_voltage_code,
   output logic [5:0]       mode_threshold_code,
   output logic [12:0]      target_mv,
   output logic [7:0]       current_limit_setup
);
   bcr_bus_if bus ();

   logic [8:0]        sync1;
   logic [8:0]        sync2;
   logic [1:0]        strap_cnt;
   logic              strap_done;
   logic [1:0]        strap_sel;
   logic [7:0]        cfg;
   logic [7:0]        output_voltage_control;
   logic [7:0]        ilim;
   logic [3:0]        rc;
   logic [2:0]        live;
   logic [7:0]        stat_byte;
   logic [7:0]        next_cfg;
   logic [7:0]        next_output_voltage_control;
   logic [7:0]        next_ilim;
   logic [3:0]        next_rc;
   logic              next_dsc;
   logic [12:0]       next_mv;
   wire logic [3:0]   evt_s;
   wire logic [2:0]   live_s;
   wire logic [1:0]   strap_s;
   wire logic         wr_cfg;
   wire logic         wr_output_voltage_control;
   wire logic         wr_ilim;
   wire logic         soft_rst;
   wire logic         rd_stat;
   wire logic         rd_ro;
   wire logic [12:0]  raw_mv;
   wire logic [12:0]  now_raw_mv;

   bcr_i2c_target u_target (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .sda_oe   (sda_oe),
      .bus      (bus.target)
   );

   assign strap_s = sync2[8:7];
   assign evt_s   = sync2[6:3];
   assign live_s  = sync2[2:0];

   // decode of host accesses
   assign wr_cfg   = bus.wr_stb && bus.addr == bcr_pkg::ADDR_CFG;
   assign wr_output_voltage_control  = bus.wr_stb && bus.addr == bcr_pkg::ADDR_OUTPUT_VOLTAGE_CONTROL;
   assign wr_ilim  = bus.wr_stb && bus.addr == bcr_pkg::ADDR_ILIM;
   assign soft_rst = wr_cfg && bus.wdata[bcr_pkg::CFG_RST];
   assign rd_stat  = bus.rd_stb && bus.addr == bcr_pkg::ADDR_STAT;
   assign rd_ro    = bus.addr == bcr_pkg::ADDR_ID
                  || bus.addr >= bcr_pkg::ADDR_STAT;

   assign bus.own_addr = {bcr_pkg::TGT_ADDR_HI, strap_sel};
   assign bus.addr_ok  = strap_done;

   // read data selection
   assign bus.rdata =
      (bus.addr == bcr_pkg::ADDR_ID)   ? {MAKER_CODE, VERSION_CODE} :
      (bus.addr == bcr_pkg::ADDR_CFG)  ? cfg :
      (bus.addr == bcr_pkg::ADDR_OUTPUT_VOLTAGE_CONTROL) ? output_voltage_control :
      (bus.addr == bcr_pkg::ADDR_ILIM) ? ilim :
      (bus.addr == bcr_pkg::ADDR_STAT) ? stat_byte :
      bcr_pkg::RD_UNMAPPED;

   always_comb
   begin
      stat_byte = 8'h00;
      stat_byte[bcr_pkg::STAT_TSD] = rc[3];
      stat_byte[bcr_pkg::STAT_PFM] = live[2];
      stat_byte[bcr_pkg::STAT_OP]  = live[1];
      stat_byte[bcr_pkg::STAT_BPS] = rc[2];
      stat_byte[bcr_pkg::STAT_BST] = rc[1];
      stat_byte[bcr_pkg::STAT_FLT] = rc[0];
      stat_byte[bcr_pkg::STAT_PG]  = live[0];
   end

   // the reset bit is never stored, so it reads back as zero
   assign next_cfg = soft_rst ? bcr_pkg::RST_CFG :
                     wr_cfg   ? {1'b0, bus.wdata[6:0]} : cfg;
   assign next_output_voltage_control = soft_rst ? bcr_pkg::RST_OUTPUT_VOLTAGE_CONTROL :
                      wr_output_voltage_control  ? bus.wdata : output_voltage_control;
   assign next_ilim = soft_rst ? bcr_pkg::RST_ILIM :
                      wr_ilim  ? bus.wdata : ilim;
   // an event in the clearing cycle survives the clear
   assign next_rc = ((soft_rst || rd_stat) ? 4'h0 : rc) | evt_s;
   assign next_dsc = ~next_cfg[bcr_pkg::CFG_EN]
                   & next_cfg[bcr_pkg::CFG_DSC];

   assign raw_mv = 13'(bcr_pkg::OUTPUT_VOLTAGE_CONTROL_BASE_MV
                 + 13'(next_output_voltage_control[5:0]) * bcr_pkg::OUTPUT_VOLTAGE_CONTROL_STEP_MV);
   assign next_mv = (raw_mv > bcr_pkg::OUTPUT_VOLTAGE_CONTROL_MAX_MV) ?
                    bcr_pkg::OUTPUT_VOLTAGE_CONTROL_MAX_MV : raw_mv;
   assign now_raw_mv = 13'(bcr_pkg::OUTPUT_VOLTAGE_CONTROL_BASE_MV
                     + 13'(output_voltage_control[5:0]) * bcr_pkg::OUTPUT_VOLTAGE_CONTROL_STEP_MV);

   always_ff @(posedge core_clk)
   begin
      sync1 <= {addr_strap, event_in, live_in};
      sync2 <= sync1;
   end

   // strap captured once, a few cycles after power-on release
   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         strap_cnt  <= 2'h0;
         strap_done <= 1'b0;
         strap_sel  <= 2'h0;
      end
      else if (!strap_done)
      begin
         strap_cnt <= 2'(strap_cnt + 2'h1);
         if (strap_cnt == bcr_pkg::STRAP_WAIT)
         begin
            strap_sel  <= strap_s;
            strap_done <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         cfg  <= bcr_pkg::RST_CFG;
         output_voltage_control <= bcr_pkg::RST_OUTPUT_VOLTAGE_CONTROL;
         ilim <= bcr_pkg::RST_ILIM;
         rc   <= 4'h0;
         live <= {bcr_pkg::RST_STAT[bcr_pkg::STAT_PFM],
                  bcr_pkg::RST_STAT[bcr_pkg::STAT_OP],
                  bcr_pkg::RST_STAT[bcr_pkg::STAT_PG]};
      end
      else
      begin
         cfg  <= next_cfg;
         output_voltage_control <= next_output_voltage_control;
         ilim <= next_ilim;
         rc   <= next_rc;
         live <= live_s;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         discharge_on <= 1'b0;
         target_mv    <= 13'h0d48;
         sda_out      <= 1'b0;
      end
      else
      begin
         discharge_on <= next_dsc;
         target_mv    <= next_mv;
         sda_out      <= 1'b0;
      end
   end

   // control outputs are register bits
   assign converter_enable          = cfg[bcr_pkg::CFG_EN];
   assign bypass_policy             = cfg[bcr_pkg::CFG_BYPH:
                                          bcr_pkg::CFG_BYPL];
   assign output_discharge_enable   = cfg[bcr_pkg::CFG_DSC];
   assign power_limit_level         = cfg[bcr_pkg::CFG_PWR];
   assign spread_spectrum_enable    = cfg[bcr_pkg::CFG_SPR];
   assign forced_pwm                = cfg[bcr_pkg::CFG_PWM];
   assign power_limit_disable       = output_voltage_control[bcr_pkg::OUTPUT_VOLTAGE_CONTROL_PLOFF];
   assign loop_adjust_on_transition = output_voltage_control[bcr_pkg::OUTPUT_VOLTAGE_CONTROL_LOOP];
   assign output_voltage_code       = output_voltage_control[bcr_pkg::OUTPUT_VOLTAGE_CONTROL_CODEH:0];
   assign mode_threshold_code       = output_voltage_control[bcr_pkg::OUTPUT_VOLTAGE_CONTROL_CODEH:0];
   assign current_limit_setup       = ilim;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   property p_tgt_addr;
      strap_done |-> bus.own_addr[6:2] == 5'h1d;
   endproperty
   a_tgt_addr: assert property (p_tgt_addr)
      else $error("target address high bits wrong");

   property p_strap_hold;
      strap_done |=> strap_done && $stable(strap_sel);
   endproperty
   a_strap_hold: assert property (p_strap_hold)
      else $error("strapped address changed");

   property p_rc_clear;
      rd_stat && !evt_s[3] |=> !rc[3];
   endproperty
   a_rc_clear: assert property (p_rc_clear)
      else $error("thermal flag not cleared by read");

   property p_set_wins;
      evt_s[3] |=> rc[3] && stat_byte[7];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("thermal trip lost");

   property p_id;
      bus.addr == 8'h00 |-> bus.rdata == {MAKER_CODE, VERSION_CODE};
   endproperty
   a_id: assert property (p_id)
      else $error("identity read wrong");

   property p_soft;
      soft_rst |=> cfg == 8'h68 && output_voltage_control == 8'h0b && ilim == 8'h16
                   && target_mv == 13'h0d48 ##1 !cfg[7];
   endproperty
   a_soft: assert property (p_soft)
      else $error("soft reset did not restore defaults");

   property p_cfg_wr;
      wr_cfg && !soft_rst |=> cfg == ($past(bus.wdata) & 8'h7f);
   endproperty
   a_cfg_wr: assert property (p_cfg_wr)
      else $error("config write not stored");

   property p_dsc;
      !converter_enable && output_discharge_enable |-> discharge_on;
   endproperty
   a_dsc: assert property (p_dsc)
      else $error("discharge not active while disabled");

   property p_mv;
      ##1 target_mv == ((now_raw_mv > 13'h1388) ? 13'h1388 : now_raw_mv);
   endproperty
   a_mv: assert property (p_mv)
      else $error("target millivolts out of step with code");

   property p_unmapped;
      bus.addr > 8'h04 |-> bus.rdata == 8'hff;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not all ones");

   property p_ro;
      bus.wr_stb && rd_ro |=> $stable(cfg) && $stable(output_voltage_control)
                              && $stable(ilim);
   endproperty
   a_ro: assert property (p_ro)
      else $error("read-only write changed state");

   property p_output_voltage_control_wr;
      wr_output_voltage_control |=> output_voltage_control == $past(bus.wdata);
   endproperty
   a_output_voltage_control_wr: assert property (p_output_voltage_control_wr)
      else $error("output register write not stored");

   c_soft: cover property (soft_rst);
   c_rd_flag: cover property (rd_stat && rc[3]);
   c_unmapped: cover property (bus.rd_stb && bus.addr > 8'h04);
   c_wr_output_voltage_control: cover property (wr_output_voltage_control ##[1:100] wr_ilim);
endmodule : bcr_boost_regs

/* File: rtl/bcr_pkg.sv */
// Purpose: shared constants and types of the boost converter register bank
// Assumes: 8-bit registers behind a two-wire serial target port
// Notes:   offsets, reset values, field positions and timing counts
package bcr_pkg;
   localparam logic [7:0] ADDR_ID     = 8'h00;
   localparam logic [7:0] ADDR_CFG    = 8'h01;
   localparam logic [7:0] ADDR_OUTPUT_VOLTAGE_CONTROL   = 8'h02;
   localparam logic [7:0] ADDR_ILIM   = 8'h03;
   localparam logic [7:0] ADDR_STAT   = 8'h04;
   localparam logic [7:0] RD_UNMAPPED = 8'hff;

   localparam logic [7:0] RST_CFG  = 8'h68;
   localparam logic [7:0] RST_OUTPUT_VOLTAGE_CONTROL = 8'h0b;
   localparam logic [7:0] RST_ILIM = 8'h16;
   localparam logic [7:0] RST_STAT = 8'h10;

   localparam int CFG_RST  = 7;
   localparam int CFG_EN   = 6;
   localparam int CFG_BYPH = 5;
   localparam int CFG_BYPL = 4;
   localparam int CFG_DSC  = 3;
   localparam int CFG_PWR  = 2;
   localparam int CFG_SPR  = 1;
   localparam int CFG_PWM  = 0;
   localparam int OUTPUT_VOLTAGE_CONTROL_PLOFF = 7;
   localparam int OUTPUT_VOLTAGE_CONTROL_LOOP  = 6;
   localparam int OUTPUT_VOLTAGE_CONTROL_CODEH = 5;

   localparam int STAT_TSD = 7;
   localparam int STAT_PFM = 5;
   localparam int STAT_OP  = 4;
   localparam int STAT_BPS = 3;
   localparam int STAT_BST = 2;
   localparam int STAT_FLT = 1;
   localparam int STAT_PG  = 0;

   // upper five bits of the 7-bit target address
   localparam logic [4:0] TGT_ADDR_HI = 5'h1d;
   // cycles after reset release before the strap is captured
   localparam logic [1:0] STRAP_WAIT  = 2'h2;

   // millivolts: base 2850, step 50, ceiling 5000
   localparam logic [12:0] OUTPUT_VOLTAGE_CONTROL_BASE_MV = 13'h0b22;
   localparam logic [12:0] OUTPUT_VOLTAGE_CONTROL_STEP_MV = 13'h0032;
   localparam logic [12:0] OUTPUT_VOLTAGE_CONTROL_MAX_MV  = 13'h1388;

   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACK_A, ST_WRITE, ST_ACK_W, ST_READ, ST_ACK_R
   } bcr_i2c_state_e;
endpackage : bcr_pkg

/* File: rtl/bcr_bus_if.sv */
// Purpose: register access strobes between serial target and register bank
// Assumes: single clock, strobes are one-cycle combinational pulses
// Notes:   addr is the auto-incrementing register pointer
`timescale 1ns/1ns
interface bcr_bus_if;
   logic [6:0] own_addr;
   logic       addr_ok;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport target (input own_addr, addr_ok, rdata,
                   output wr_stb, rd_stb, addr, wdata);
   modport bank   (output own_addr, addr_ok, rdata,
                   input wr_stb, rd_stb, addr, wdata);
endinterface : bcr_bus_if

/* File: rtl/bcr_i2c_target.sv */
// Purpose: two-wire serial target, byte framing, ack and register pointer
// Assumes: scl and sda arrive asynchronously, sda is open drain
// Notes:   no clock stretching; first written byte loads the pointer
`timescale 1ns/1ns
module bcr_i2c_target (
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_oe,
   bcr_bus_if.target bus
);
   logic [2:0]                  scl_q;
   logic [2:0]                  sda_q;
   bcr_pkg::bcr_i2c_state_e     state;
   logic [7:0]                  sh;
   logic [3:0]                  cnt;
   logic                        rw;
   logic                        first;
   logic                        nack;
   logic [7:0]                  ptr;
   wire logic                   scl_rise;
   wire logic                   scl_fall;
   wire logic                   start_c;
   wire logic                   stop_c;
   wire logic                   load_tx;
   wire logic                   wr_go;

   assign scl_rise = scl_q[1] & ~scl_q[2];
   assign scl_fall = ~scl_q[1] & scl_q[2];
   assign start_c  = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
   assign stop_c   = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
   assign load_tx  = scl_fall & ~start_c & ~stop_c
                   & ((state == bcr_pkg::ST_ACK_A & rw)
                   | (state == bcr_pkg::ST_ACK_R & ~nack));
   assign wr_go    = scl_fall & state == bcr_pkg::ST_WRITE
                   & cnt == 4'h8 & ~first;
   assign bus.rd_stb = load_tx;
   assign bus.wr_stb = wr_go;
   assign bus.addr   = ptr;
   assign bus.wdata  = sh;

   // q[0] feeds only q[1]; q[2] keeps the previous synchronised level
   always_ff @(posedge core_clk)
   begin
      scl_q <= {scl_q[1:0], scl_in};
      sda_q <= {sda_q[1:0], sda_in};
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         state  <= bcr_pkg::ST_IDLE;
         sh     <= 8'h00;
         cnt    <= 4'h0;
         rw     <= 1'b0;
         first  <= 1'b0;
         nack   <= 1'b0;
         ptr    <= 8'h00;
         sda_oe <= 1'b0;
      end
      else if (stop_c)
      begin
         state  <= bcr_pkg::ST_IDLE;
         sda_oe <= 1'b0;
      end
      else if (start_c)
      begin
         state  <= bcr_pkg::ST_ADDR;
         cnt    <= 4'h0;
         sda_oe <= 1'b0;
      end
      else if (scl_rise)
      begin
         if (state == bcr_pkg::ST_ADDR || state == bcr_pkg::ST_WRITE)
         begin
            sh  <= {sh[6:0], sda_q[1]};
            cnt <= 4'(cnt + 4'h1);
         end
         else if (state == bcr_pkg::ST_READ)
            cnt <= 4'(cnt + 4'h1);
         else if (state == bcr_pkg::ST_ACK_R)
            nack <= sda_q[1];
      end
      else if (load_tx)
      begin
         // reads walk upward through the map
         sh     <= bus.rdata;
         sda_oe <= ~bus.rdata[7];
         ptr    <= 8'(ptr + 8'h01);
         cnt    <= 4'h0;
         state  <= bcr_pkg::ST_READ;
      end
      else if (scl_fall)
      begin
         case (state)
            bcr_pkg::ST_ADDR:
               if (cnt == 4'h8)
               begin
                  if (sh[7:1] == bus.own_addr && bus.addr_ok)
                  begin
                     sda_oe <= 1'b1;
                     rw     <= sh[0];
                     state  <= bcr_pkg::ST_ACK_A;
                  end
                  else
                     state <= bcr_pkg::ST_IDLE;
               end
            bcr_pkg::ST_WRITE:
               if (cnt == 4'h8)
               begin
                  // every byte is acked, read-only targets too
                  sda_oe <= 1'b1;
                  state  <= bcr_pkg::ST_ACK_W;
                  first  <= 1'b0;
                  if (first)
                     ptr <= sh;
                  else
                     ptr <= 8'(ptr + 8'h01);
               end
            bcr_pkg::ST_ACK_A, bcr_pkg::ST_ACK_W:
            begin
               first  <= (state == bcr_pkg::ST_ACK_A);
               sda_oe <= 1'b0;
               cnt    <= 4'h0;
               state  <= bcr_pkg::ST_WRITE;
            end
            bcr_pkg::ST_READ:
               if (cnt == 4'h8)
               begin
                  sda_oe <= 1'b0;
                  state  <= bcr_pkg::ST_ACK_R;
               end
               else
               begin
                  sda_oe <= ~sh[6];
                  sh     <= {sh[6:0], 1'b0};
               end
            bcr_pkg::ST_ACK_R:
            begin
               sda_oe <= 1'b0;
               state  <= bcr_pkg::ST_IDLE;
            end
            default:
               state <= bcr_pkg::ST_IDLE;
         endcase
      end
   end

   property p_ptr_inc;
      @(posedge core_clk) disable iff (!rst_b)
      wr_go |=> ptr == 8'($past(ptr) + 8'h01);
   endproperty
   a_ptr_inc: assert property (p_ptr_inc)
      else $error("pointer did not advance after a write");
endmodule : bcr_i2c_target

/* File: sim/bcr_host_model.sv */
// Purpose: behavioural host that drives the two-wire link of the bank
// Assumes: open-drain lines with pull-ups, SCL half period of 4 cycles
// Notes:   SCL stands high between frames; released SDA reads high
`timescale 1ns/1ns
module bcr_host_model (
   input  wire logic core_clk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   // start or repeated start; leaves SCL low
   task automatic start;
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask : start

   task automatic stop;
      sda_low <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_low <= 1'b0;
      tick(4);
   endtask : stop

   // data changes only while SCL is low
   task automatic put_bit(input logic b);
      sda_low <= ~b;
      tick(2);
      scl <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask : put_bit

   task automatic get_bit(output logic b);
      sda_low <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(3);
      #1 b = sda;
      tick(1);
      scl <= 1'b0;
      tick(2);
   endtask : get_bit

   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
         put_bit(d[i]);
      get_bit(b);
      ack = ~b;
   endtask : send_byte

   task automatic recv_byte(output logic [7:0] d, input logic last);
      for (int i = 7; i >= 0; i--)
         get_bit(d[i]);
      put_bit(last);
   endtask : recv_byte
endmodule : bcr_host_model

/* File: sim/bcr_boost_regs_test.sv */
// Purpose: self-checking bench of the boost converter register bank
// Assumes: host model on the link, strap 01 at power-on
// Notes:   one task per scenario; flags raised through event_in
`timescale 1ns/1ns
module bcr_boost_regs_test;
   localparam logic [3:0] MK = 4'h9; // arbitrary value
   localparam logic [3:0] VR = 4'h4; // arbitrary value
   logic        core_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        scl_in, sda_in, sda_out, sda_oe, scl, sda_low, ok;
   logic        converter_enable, output_discharge_enable, discharge_on;
   logic        power_limit_level, power_limit_disable, forced_pwm;
   logic        spread_spectrum_enable, loop_adjust_on_transition;
   logic [1:0]  bypass_policy, addr_strap;
   logic [5:0]  output_voltage_code, mode_threshold_code;
   logic [12:0] target_mv;
   logic [7:0]  current_limit_setup;
   logic [3:0]  event_in;
   logic [2:0]  live_in;
   logic [6:0]  dev_adr = 7'h75;
   logic [7:0]  rq [$];
   int          fail_count = 0;
   int          checks = 0;
   int          cycles = 0;

   // open-drain data wire with pull-up
   assign sda_in = ~(sda_low | sda_oe);
   assign scl_in = scl;

   always #20 core_clk = ~core_clk;

   bcr_boost_regs #(.MAKER_CODE(MK), .VERSION_CODE(VR)) dut (
      .core_clk, .rst_b, .scl_in, .sda_in, .sda_out, .sda_oe, .addr_strap,
      .event_in, .live_in, .converter_enable, .bypass_policy,
      .output_discharge_enable, .discharge_on, .power_limit_level,
      .power_limit_disable, .spread_spectrum_enable, .forced_pwm,
      .loop_adjust_on_transition, .output_voltage_code,
      .mode_threshold_code, .target_mv, .current_limit_setup);

   bcr_host_model u_host (.core_clk, .sda(sda_in), .scl, .sda_low);

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic wr(input logic [7:0] ptr, input logic [7:0] d [$],
                     output logic ok);
      logic a;
      u_host.start();
      u_host.send_byte({dev_adr, 1'b0}, ok);
      u_host.send_byte(ptr, a);
      ok = ok & a;
      foreach (d[i])
      begin
         u_host.send_byte(d[i], a);
         ok = ok & a;
      end
      u_host.stop();
   endtask : wr

   task automatic chk_rd(input logic [7:0] ptr, input logic [7:0] e [$]);
      logic       a;
      logic [7:0] d;
      u_host.start();
      u_host.send_byte({dev_adr, 1'b0}, a);
      u_host.send_byte(ptr, a);
      u_host.start();
      u_host.send_byte({dev_adr, 1'b1}, a);
      foreach (e[i])
      begin
         u_host.recv_byte(d, i == e.size() - 1);
         check(d, e[i]);
      end
      u_host.stop();
   endtask : chk_rd

   task automatic t_reset;
      chk_rd(8'h00, '{{MK, VR}, 8'h68, 8'h0b, 8'h16, 8'h10,
                      8'hff});
      check(target_mv, 13'h0d48);
      check({converter_enable, bypass_policy, output_discharge_enable},
            4'b1101);
      check(discharge_on, 1'b0);
      check(sda_out, 1'b0);
      $display("test reset defaults done");
   endtask : t_reset

   task automatic t_addr;
      dev_adr = 7'h76;
      wr(8'h03, '{8'h00}, ok);
      check(ok, 1'b0);
      dev_adr = 7'h35;
      wr(8'h03, '{8'h00}, ok);
      check(ok, 1'b0);
      check(current_limit_setup, 8'h16);
      addr_strap <= 2'b10;
      dev_adr = 7'h76;
      wr(8'h03, '{8'h00}, ok);
      check(ok, 1'b0);
      dev_adr = 7'h75;
      wr(8'h03, '{8'h16}, ok);
      check(ok, 1'b1);
      $display("test target address done");
   endtask : t_addr

   task automatic t_write;
      wr(8'h01, '{8'h17, 8'hc5, 8'h2a}, ok);
      check(ok, 1'b1);
      check({converter_enable, bypass_policy, output_discharge_enable,
             power_limit_level, spread_spectrum_enable, forced_pwm},
            8'h17);
      check({power_limit_disable, loop_adjust_on_transition,
             output_voltage_code}, 8'hc5);
      check(mode_threshold_code, 6'h05);
      check(target_mv, 13'h0c1c);
      check(current_limit_setup, 8'h2a);
      check(discharge_on, 1'b0);
      chk_rd(8'h01, '{8'h17, 8'hc5, 8'h2a});
      wr(8'h01, '{8'h08, 8'h3f}, ok);
      check(discharge_on, 1'b1);
      check(target_mv, 13'h1388);
      wr(8'h02, '{8'h2a}, ok);
      check(target_mv, 13'h1356);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h01, '{{2'b01, i[1:0], 4'h8}}, ok);
         check(bypass_policy, i[1:0]);
         check(discharge_on, 1'b0);
      end
      $display("test configuration writes done");
   endtask : t_write

   task automatic t_ro;
      wr(8'h04, '{8'h00, 8'h12}, ok);
      check(ok, 1'b1);
      wr(8'h00, '{8'h00}, ok);
      check(ok, 1'b1);
      chk_rd(8'h00, '{{MK, VR}, 8'h78});
      chk_rd(8'h04, '{8'h10, 8'hff});
      $display("test read-only places done");
   endtask : t_ro

   task automatic t_flags;
      event_in <= 4'hf;
      repeat (2) @(posedge core_clk);
      event_in <= 4'h0;
      live_in <= 3'b101;
      chk_rd(8'h04, '{8'haf});
      chk_rd(8'h04, '{8'h21});
      live_in <= 3'b010;
      $display("test status flags done");
   endtask : t_flags

   task automatic t_softrst;
      event_in <= 4'h8;
      repeat (2) @(posedge core_clk);
      event_in <= 4'h0;
      wr(8'h01, '{8'h80}, ok);
      check(ok, 1'b1);
      chk_rd(8'h01, '{8'h68, 8'h0b, 8'h16, 8'h10});
      check(target_mv, 13'h0d48);
      $display("test soft reset done");
   endtask : t_softrst

   initial
   begin
      addr_strap = 2'b01;
      event_in = 4'h0;
      live_in = 3'b010;
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (12) @(posedge core_clk);
      t_reset();
      t_addr();
      t_write();
      t_ro();
      t_flags();
      t_softrst();
      tally_and_finish();
   end
endmodule : bcr_boost_regs_test
